/* File: rtl/qrfs_params.svh */
// Timing constants for the flyback switch timing core.
// Assumes a 100 MHz core clock; cycle counts derive from the figures below.
`ifndef QRFS_PARAMS_SVH
`define QRFS_PARAMS_SVH

`define QRFS_CLK_MHZ          100
`define QRFS_DEMAG_TOUT_US    5
`define QRFS_DEMAG_TOUT_CYC   (`QRFS_DEMAG_TOUT_US * `QRFS_CLK_MHZ)
`define QRFS_OVP_RUN          7
`define QRFS_BURST_KHZ        22
`define QRFS_BURST_CYC        ((`QRFS_CLK_MHZ * 1000) / `QRFS_BURST_KHZ)
`define QRFS_CLAMP_H_KHZ      130
`define QRFS_CLAMP_H_CYC      ((`QRFS_CLK_MHZ * 1000 + `QRFS_CLAMP_H_KHZ - 1) / `QRFS_CLAMP_H_KHZ)
`define QRFS_CLAMP_L_KHZ      22
`define QRFS_CLAMP_L_CYC      ((`QRFS_CLK_MHZ * 1000) / `QRFS_CLAMP_L_KHZ)
`define QRFS_TON_MAX_US       30
`define QRFS_TON_MAX_CYC      (`QRFS_TON_MAX_US * `QRFS_CLK_MHZ)
`define QRFS_TOFF_MAX_US      50
`define QRFS_TOFF_MAX_CYC     (`QRFS_TOFF_MAX_US * `QRFS_CLK_MHZ)
`define QRFS_SUPP_US          2
`define QRFS_SUPP_CYC         (`QRFS_SUPP_US * `QRFS_CLK_MHZ)
`define QRFS_BLANK_NS         350
`define QRFS_BLANK_CYC        ((`QRFS_BLANK_NS * `QRFS_CLK_MHZ + 999) / 1000)
`define QRFS_BROWNOUT_MS      50
`define QRFS_BROWNOUT_CYC     (`QRFS_BROWNOUT_MS * `QRFS_CLK_MHZ * 1000)
`define QRFS_SKIP_MAX         3

`endif

/* File: rtl/qrfs_pkg.sv */
// Types for the flyback switch timing core.
// Assumes qrfs_params.svh for numeric constants.
package qrfs_pkg;
  typedef enum logic [1:0] {
    QRFS_VALLEY   = 2'h0,
    QRFS_FOLDBACK = 2'h1,
    QRFS_BURST    = 2'h2
  } qrfs_mode_t;

  typedef enum logic [1:0] {
    QRFS_SOFT = 2'h0,
    QRFS_ON   = 2'h1,
    QRFS_OFF  = 2'h2,
    QRFS_HALT = 2'h3
  } qrfs_state_t;
endpackage : qrfs_pkg

/* File: rtl/qrfs_sync.sv */
// Two-flop synchroniser bank for the comparator flags.
// Assumes inputs are asynchronous levels; outputs are registered.
module qrfs_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Flags
  input  wire logic [W-1:0] dIn,
  output logic      [W-1:0] qOut
);
  logic [W-1:0] meta_r;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[g] <= 1'b0;
          qOut[g]   <= 1'b0;
        end else begin
          meta_r[g] <= dIn[g];
          qOut[g]   <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule : qrfs_sync

/* File: rtl/qrfs_switch_timing.sv */
// Switch timing and mode core of a quasi-resonant flyback controller.
// Assumes comparator flags arrive asynchronously; rst_n is supply lockout.
`include "qrfs_params.svh"

module qrfs_switch_timing #(
  parameter int BROWNOUT_CYC = `QRFS_BROWNOUT_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Feedback comparators
  input  wire logic feedbackAboveFoldback,
  input  wire logic feedbackAboveBurst,
  input  wire logic feedbackSkipLow,
  input  wire logic feedbackSkipMid,
  // Sense comparators
  input  wire logic currentAtLimit,
  input  wire logic auxWindingSense,
  input  wire logic plateauOverTrip,
  input  wire logic lineSenseLow,
  input  wire logic lineSenseHigh,
  input  wire logic softStartDone,
  input  wire logic softStartLatch,
  input  wire logic supplyLowBurst,
  // Drive and status
  output logic      switchDrive_r,
  output qrfs_pkg::qrfs_mode_t modeOut_r,
  output logic      softStartActive_r,
  output logic      faultLatched_r,
  output logic      brownout_r,
  output logic      lineOverVoltage_r
);
  import qrfs_pkg::*;

  localparam logic [15:0] TOUT_CYC  = 16'(`QRFS_DEMAG_TOUT_CYC);
  localparam logic [15:0] BURST_CYC = 16'(`QRFS_BURST_CYC);
  localparam logic [15:0] HI_CYC    = 16'(`QRFS_CLAMP_H_CYC);
  localparam logic [15:0] LO_CYC    = 16'(`QRFS_CLAMP_L_CYC);
  localparam logic [15:0] TON_CYC   = 16'(`QRFS_TON_MAX_CYC);
  localparam logic [15:0] TOFF_CYC  = 16'(`QRFS_TOFF_MAX_CYC);
  localparam logic [15:0] SUPP_CYC  = 16'(`QRFS_SUPP_CYC);
  localparam logic [15:0] BLANK_CYC = 16'(`QRFS_BLANK_CYC);
  localparam logic [2:0]  OVP_RUN   = 3'(`QRFS_OVP_RUN);
  localparam logic [1:0]  SKIP_MAX  = 2'(`QRFS_SKIP_MAX);
  localparam logic [22:0] BO_CYC    = 23'(BROWNOUT_CYC);

  // Synchronised flags
  logic [11:0] rawFlags;
  logic [11:0] syncFlags;
  assign rawFlags = {supplyLowBurst, softStartLatch, softStartDone, lineSenseHigh,
                     lineSenseLow, plateauOverTrip, auxWindingSense, currentAtLimit,
                     feedbackSkipMid, feedbackSkipLow, feedbackAboveBurst,
                     feedbackAboveFoldback};

  qrfs_sync #(.W(12)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .dIn   (rawFlags),
    .qOut  (syncFlags)
  );

  wire fbFold  = syncFlags[0];
  wire fbBurst = syncFlags[1];
  wire skipLo  = syncFlags[2];
  wire skipMid = syncFlags[3];
  wire csLimit = syncFlags[4];
  wire auxS    = syncFlags[5];
  wire ovpTrip = syncFlags[6];
  wire lineLo  = syncFlags[7];
  wire lineHi  = syncFlags[8];
  wire ssDone  = syncFlags[9];
  wire ssLatch = syncFlags[10];
  wire vccLow  = syncFlags[11];

  // State
  qrfs_state_t state_r, state_nxt;
  logic [15:0] onCnt_r, offCnt_r, perCnt_r, demagCnt_r, foldOn_r;
  logic        auxPrev_r;
  logic [1:0]  skipCnt_r;
  logic [2:0]  ovpCnt_r;
  logic        ovpSampled_r;
  logic [22:0] boCnt_r;

  // Mode from feedback level
  qrfs_mode_t modeSel;
  assign modeSel = fbFold  ? QRFS_VALLEY :
                   fbBurst ? QRFS_FOLDBACK :
                             QRFS_BURST;

  // Valleys to skip in foldback grows as feedback falls
  logic [1:0] skipNeed;
  assign skipNeed = (modeOut_r != QRFS_FOLDBACK) ? 2'h0 :
                    skipLo  ? SKIP_MAX :
                    skipMid ? 2'h2 : 2'h1;

  wire inSupp    = offCnt_r < SUPP_CYC;
  wire auxFall   = auxPrev_r && !auxS;
  wire valleyOk  = auxFall && !inSupp;
  wire valleyUse = valleyOk && (skipCnt_r >= skipNeed);
  wire demagTout = demagCnt_r >= TOUT_CYC;
  wire minPerOk  = perCnt_r >= HI_CYC - 16'h1;
  wire lowClamp  = perCnt_r >= LO_CYC - 16'h1;
  wire offMax    = offCnt_r >= TOFF_CYC - 16'h1;
  wire burstTick = perCnt_r >= BURST_CYC - 16'h1;

  wire fault = faultLatched_r || brownout_r || lineOverVoltage_r;

  // Turn-on decision per mode
  logic startReq;
  always_comb begin
    startReq = 1'b0;
    case (modeOut_r)
      QRFS_BURST: begin
        startReq = burstTick && (vccLow || csLimit == 1'b0 && fbBurst);
      end
      default: begin
        startReq = minPerOk && (valleyUse || demagTout || lowClamp || offMax);
      end
    endcase
    if (inSupp) begin
      startReq = 1'b0;
    end
  end

  // Turn-off decision
  wire blanking = onCnt_r < BLANK_CYC - 16'h1;
  wire csStop   = csLimit && !blanking;
  wire foldStop = (modeOut_r == QRFS_FOLDBACK) && (onCnt_r >= foldOn_r) && !blanking;
  wire tonStop  = onCnt_r >= TON_CYC - 16'h1;
  wire offReq   = csStop || foldStop || tonStop;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      QRFS_SOFT: begin
        if (ssDone) state_nxt = QRFS_OFF;
      end
      QRFS_ON: begin
        if (offReq) state_nxt = QRFS_OFF;
      end
      QRFS_OFF: begin
        if (startReq) state_nxt = QRFS_ON;
      end
      QRFS_HALT: begin
        state_nxt = QRFS_HALT;
      end
      default: state_nxt = QRFS_SOFT;
    endcase
    if (fault) begin
      state_nxt = QRFS_HALT;
    end else if (state_r == QRFS_HALT) begin
      state_nxt = QRFS_SOFT;
    end
  end

  // Soft start holds the drive off and only restarts the period timer each low-clamp period
  wire softStart = (state_r == QRFS_SOFT) && perCnt_r >= LO_CYC - 16'h1;
  wire turnOn    = (state_r == QRFS_OFF) && (state_nxt == QRFS_ON);
  wire turnOff   = (state_r == QRFS_ON) && (state_nxt != QRFS_ON);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= QRFS_SOFT;
      modeOut_r <= QRFS_VALLEY;
      auxPrev_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      auxPrev_r <= auxS;
      if (turnOn) begin
        modeOut_r <= modeSel;
      end
    end
  end

  // Cycle timers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      onCnt_r    <= 16'h0;
      offCnt_r   <= 16'h0;
      perCnt_r   <= 16'h0;
      demagCnt_r <= 16'h0;
      skipCnt_r  <= 2'h0;
    end else begin
      onCnt_r  <= turnOn ? 16'h0 : (state_r == QRFS_ON && onCnt_r != 16'hFFFF) ? onCnt_r + 16'h1 : onCnt_r;
      offCnt_r <= turnOff ? 16'h0 : (state_r != QRFS_ON && offCnt_r != 16'hFFFF) ? offCnt_r + 16'h1 : offCnt_r;
      perCnt_r <= (turnOn || softStart) ? 16'h0 : (perCnt_r != 16'hFFFF) ? perCnt_r + 16'h1 : perCnt_r;
      if (turnOff || auxS != auxPrev_r) begin
        demagCnt_r <= 16'h0;
      end else if (state_r == QRFS_OFF && demagCnt_r != 16'hFFFF) begin
        demagCnt_r <= demagCnt_r + 16'h1;
      end
      if (turnOn) begin
        skipCnt_r <= 2'h0;
      end else if (valleyOk && skipCnt_r != 2'h3) begin
        skipCnt_r <= skipCnt_r + 2'h1;
      end
    end
  end

  // Foldback on-time is frozen at the last valley-mode on-time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      foldOn_r <= TON_CYC;
    end else if (turnOff && modeOut_r == QRFS_VALLEY) begin
      foldOn_r <= onCnt_r;
    end
  end

  // Plateau sampled once per cycle at end of suppression interval
  wire plateauSample = (state_r == QRFS_OFF) && (offCnt_r == SUPP_CYC);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovpCnt_r       <= 3'h0;
      ovpSampled_r   <= 1'b0;
      faultLatched_r <= 1'b0;
    end else begin
      if (turnOn && !ovpSampled_r) begin
        ovpCnt_r <= 3'h0;
      end else if (plateauSample) begin
        ovpCnt_r <= ovpTrip ? ovpCnt_r + 3'h1 : 3'h0;
      end
      ovpSampled_r <= turnOn ? 1'b0 : (plateauSample ? 1'b1 : ovpSampled_r);
      if ((plateauSample && ovpTrip && ovpCnt_r == OVP_RUN - 3'h1) || ssLatch) begin
        faultLatched_r <= 1'b1;
      end
    end
  end

  // Line protections
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      boCnt_r           <= 23'h0;
      brownout_r        <= 1'b0;
      lineOverVoltage_r <= 1'b0;
    end else begin
      boCnt_r           <= !lineLo ? 23'h0 : (boCnt_r != BO_CYC) ? boCnt_r + 23'h1 : boCnt_r;
      brownout_r        <= lineLo && boCnt_r >= BO_CYC - 23'h1;
      lineOverVoltage_r <= lineHi;
    end
  end

  // Drive output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      switchDrive_r     <= 1'b0;
      softStartActive_r <= 1'b1;
    end else begin
      switchDrive_r     <= (state_nxt == QRFS_ON) && !fault;
      softStartActive_r <= (state_nxt == QRFS_SOFT);
    end
  end

  a_ton_limit: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == QRFS_ON |-> onCnt_r < TON_CYC) else $error("On-time exceeded limit");
  a_no_supp_on: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(switchDrive_r) |-> offCnt_r >= SUPP_CYC - 16'h1) else $error("Turn-on in suppression");
  a_fault_low: assert property (@(posedge clk) disable iff (!rst_n)
    $past(fault) && fault |-> !switchDrive_r) else $error("Drive high with fault");
  a_latch_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    faultLatched_r |=> faultLatched_r) else $error("Latched fault released");
  a_toff_limit: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == QRFS_OFF && !fault && modeOut_r != QRFS_BURST |-> offCnt_r < TOFF_CYC + HI_CYC)
    else $error("Off-time exceeded limit");
  a_min_period: assert property (@(posedge clk) disable iff (!rst_n)
    turnOn && modeOut_r != QRFS_BURST |-> perCnt_r >= HI_CYC - 16'h1) else $error("Period short");
  a_blank_hold: assert property (@(posedge clk) disable iff (!rst_n)
    turnOff && !fault |-> onCnt_r >= BLANK_CYC - 16'h1) else $error("On-time under blanking");
  a_lineov_stop: assert property (@(posedge clk) disable iff (!rst_n)
    lineHi |=> ##1 !switchDrive_r) else $error("Drive during line over-voltage");
endmodule : qrfs_switch_timing

/* File: test/qrfs_switch_model.sv */
// Behavioural power switch, sense resistor and auxiliary winding.
// Assumes the bench changes the knobs only between switching cycles.
module qrfs_switch_model (
  // Clock
  input  wire logic        clk,
  // Drive and knobs
  input  wire logic        drive,
  input  wire logic [15:0] onCyc,
  input  wire logic [15:0] demagCyc,
  input  wire logic        limitEn,
  input  wire logic        valleyEn,
  // Comparator flags
  output logic             currentHigh,
  output logic             auxHigh
);
  timeunit 1ns;
  timeprecision 1ps;

  int   cnt  = 0;
  logic prev = 1'b0;

  initial begin
    currentHigh = 1'b0;
    auxHigh = 1'b1;
  end

  // With valleys off the winding never rings down, so only a timeout restarts
  // After demagnetisation the drain rings, giving a valley every 4 cycles
  always @(negedge clk) begin
    cnt         <= (drive != prev) ? 0 : cnt + 1;
    prev        <= drive;
    currentHigh <= drive && limitEn && (cnt >= onCyc);
    auxHigh     <= !drive && (!valleyEn || cnt < demagCyc || cnt[1]);
  end
endmodule : qrfs_switch_model

/* File: test/tb_qr_flyback_switch_timing.sv */
// Self-checking bench for the flyback switch timing core.
// Assumes qrfs_switch_model as the switch; brownout count shortened to 100.
module tb_qr_flyback_switch_timing;
  import qrfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, rst_n = 1'b0;
  logic        fbFold = 1'b1, fbBurst = 1'b1, plateau = 1'b0;
  logic        lineLow = 1'b0, lineHigh = 1'b0, ssDone = 1'b0;
  logic        ssLatch = 1'b0, supLow = 1'b0, limitEn = 1'b1, valleyEn = 1'b1;
  logic        skipLo = 1'b0, skipMid = 1'b0;
  logic [15:0] onCyc = 16'h01F4, demagCyc = 16'h012C;
  logic        curHigh, auxHigh, drv, ssAct, fault, brown, lineOv;
  qrfs_mode_t  mode;
  int          err_total = 0, checked = 0;

  always #5 clk = ~clk;

  qrfs_switch_timing #(.BROWNOUT_CYC(100)) qrfs_switch_timing_inst (
    .clk(clk), .rst_n(rst_n), .feedbackAboveFoldback(fbFold),
    .feedbackAboveBurst(fbBurst), .feedbackSkipLow(skipLo), .feedbackSkipMid(skipMid),
    .currentAtLimit(curHigh), .auxWindingSense(auxHigh), .plateauOverTrip(plateau),
    .lineSenseLow(lineLow), .lineSenseHigh(lineHigh), .softStartDone(ssDone),
    .softStartLatch(ssLatch), .supplyLowBurst(supLow), .switchDrive_r(drv),
    .modeOut_r(mode), .softStartActive_r(ssAct), .faultLatched_r(fault),
    .brownout_r(brown), .lineOverVoltage_r(lineOv));

  qrfs_switch_model qrfs_switch_model_inst (
    .clk(clk), .drive(drv), .onCyc(onCyc), .demagCyc(demagCyc),
    .limitEn(limitEn), .valleyEn(valleyEn), .currentHigh(curHigh), .auxHigh(auxHigh));

  task automatic chk(input string n, input int lo, input int hi, input int v);
    checked++;
    if (v < lo || v > hi) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", n, lo, hi, v);
    end
  endtask : chk

  task automatic chkb(input string n, input logic [1:0] e, input logic [1:0] v);
    checked++;
    if (v !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, v);
    end
  endtask : chkb

  // Sampled on the falling edge so registered outputs have settled
  task automatic pulse(output int onT, output int offT);
    int n;
    n = 0;
    while (drv !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    onT = 0;
    while (drv === 1'b1 && onT < 9000) begin
      @(negedge clk);
      onT++;
    end
    offT = 0;
    while (drv !== 1'b1 && offT < 9000) begin
      @(negedge clk);
      offT++;
    end
  endtask : pulse

  task automatic quiet(input string n, input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(negedge clk);
      if (drv !== 1'b0) seen = 1'b1;
    end
    chkb(n, 2'h0, {1'b0, seen});
  endtask : quiet

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset

  task automatic t_start();
    int onT, offT;
    chkb("drive", 2'h0, {1'b0, drv});
    chkb("softstart", 2'h1, {1'b0, ssAct});
    quiet("idle in soft start", 1000);
    ssDone = 1'b1;
    pulse(onT, offT);
    pulse(onT, offT);
    chk("on time", 500, 510, onT);
    chk("valley off", 300, 310, offT);
    chkb("mode", 2'h0, mode);
    chkb("softstart", 2'h0, {1'b0, ssAct});
    $display("test start done");
  endtask : t_start

  task automatic t_limits();
    int onT, offT;
    onCyc = 16'h0000;
    pulse(onT, offT);
    pulse(onT, offT);
    chk("blanked on", 35, 45, onT);
    chk("high clamp", 770, 776, onT + offT);
    onCyc = 16'h01F4;
    demagCyc = 16'h000A;
    pulse(onT, offT);
    pulse(onT, offT);
    chk("suppressed off", 200, 520, offT);
    valleyEn = 1'b0;
    pulse(onT, offT);
    pulse(onT, offT);
    chk("timeout off", 500, 512, offT);
    valleyEn = 1'b1;
    demagCyc = 16'h012C;
    limitEn = 1'b0;
    pulse(onT, offT);
    pulse(onT, offT);
    chk("max on", 3000, 3008, onT);
    limitEn = 1'b1;
    $display("test limits done");
  endtask : t_limits

  task automatic t_modes();
    int onT, offT, offOne;
    fbFold = 1'b0;
    pulse(onT, offT);
    pulse(onT, offT);
    chkb("foldback mode", 2'h1, mode);
    offOne = offT;
    skipMid = 1'b1;
    pulse(onT, offT);
    pulse(onT, offT);
    chk("mid skip", 4, 4, offT - offOne);
    skipLo = 1'b1;
    pulse(onT, offT);
    pulse(onT, offT);
    chk("low skip", 8, 8, offT - offOne);
    skipLo = 1'b0;
    skipMid = 1'b0;
    fbBurst = 1'b0;
    supLow = 1'b1;
    onCyc = 16'h0032;
    pulse(onT, offT);
    pulse(onT, offT);
    chk("burst period", 4540, 4550, onT + offT);
    chkb("burst mode", 2'h2, mode);
    supLow = 1'b0;
    repeat (100) @(negedge clk);
    quiet("burst hold off", 6000);
    fbBurst = 1'b1;
    fbFold = 1'b1;
    onCyc = 16'h01F4;
    $display("test modes done");
  endtask : t_modes

  task automatic t_line();
    lineHigh = 1'b1;
    repeat (10) @(negedge clk);
    chkb("line high flag", 2'h1, {1'b0, lineOv});
    quiet("line high stop", 2000);
    lineHigh = 1'b0;
    lineLow = 1'b1;
    repeat (90) @(negedge clk);
    chkb("brownout early", 2'h0, {1'b0, brown});
    repeat (20) @(negedge clk);
    chkb("brownout", 2'h1, {1'b0, brown});
    lineLow = 1'b0;
    $display("test line done");
  endtask : t_line

  task automatic t_faults();
    int onT, offT;
    pulse(onT, offT);
    // A clean cycle at seven restarts the run, so the fault waits for 14
    for (int k = 1; k <= 14; k++) begin
      plateau = (k != 7);
      pulse(onT, offT);
      chkb("ovp fault", {1'b0, k == 14}, {1'b0, fault});
    end
    plateau = 1'b0;
    quiet("fault stop", 500);
    do_reset();
    chkb("fault cleared", 2'h0, {1'b0, fault});
    pulse(onT, offT);
    ssLatch = 1'b1;
    repeat (20) @(negedge clk);
    ssLatch = 1'b0;
    quiet("latched off", 2000);
    chkb("latch fault", 2'h1, {1'b0, fault});
    do_reset();
    chkb("latch released", 2'h0, {1'b0, fault});
    $display("test faults done");
  endtask : t_faults

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    do_reset();
    t_start();
    t_limits();
    t_modes();
    t_line();
    t_faults();
    give_verdict();
  end

  // Sized well above the roughly 55k cycles the tests need
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    give_verdict();
  end
endmodule : tb_qr_flyback_switch_timing
